// ===== verilog/paf_override_defs.vh
// constants of the port alternate-function override block
// assumes byte addresses on an apb bus with 32-bit data
`ifndef PAF_OVERRIDE_DEFS_VH
`define PAF_OVERRIDE_DEFS_VH

// register byte offsets
`define PAF_OFF_CTRL      8'h00
`define PAF_OFF_SRC_MASK  8'h04
`define PAF_OFF_DIG_DIS   8'h08
`define PAF_OFF_IE_STAT   8'h0c
`define PAF_OFF_OVR_STAT  8'h10

// control register fields
`define PAF_CTRL_RELOCATE   0
`define PAF_CTRL_GROUP0_EN  1
`define PAF_CTRL_GROUP1_EN  2
`define PAF_CTRL_RST_DIS    3
`define PAF_CTRL_CLK_OUT    4
`define PAF_CTRL_WIDTH      5

// widths of the other registers
`define PAF_SRC_WIDTH   12
`define PAF_DIS_WIDTH   8
`define PAF_PIN_COUNT   12

// reset values
`define PAF_CTRL_RESET  5'h00
`define PAF_SRC_RESET   12'h000
`define PAF_DIS_RESET   8'h00

// pin positions inside the 12-bit pin vectors
`define PAF_PA0  0
`define PAF_PA1  1
`define PAF_PA2  2
`define PAF_PA3  3
`define PAF_PA4  4
`define PAF_PA5  5
`define PAF_PA6  6
`define PAF_PA7  7
`define PAF_PB0  8
`define PAF_PB1  9
`define PAF_PB2  10
`define PAF_PB3  11

`endif

// ===== verilog/paf_override.v
// override logic for the alternate functions of port a (8 pins) and port b (4 pins)
// assumes peripherals and pad logic share clk_i; pads arrive asynchronous
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "paf_override_defs.vh"

module paf_override (
  // clock, enable and reset
  input  wire        clk_i,
  input  wire        ce_i,
  input  wire        resetn_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  // timer, serial, comparator and clock system
  input  wire        compare_a_output_i,
  input  wire        compare_a_en_i,
  input  wire        compare_b_output_i,
  input  wire        compare_b_en_i,
  input  wire        comparator_result_i,
  input  wire        comparator_output_pin_en_i,
  input  wire        receiver_enable_i,
  input  wire        transmitter_enable_i,
  input  wire        transmit_serial_bit_i,
  input  wire        external_clock_selected_i,
  input  wire        power_down_sleep_i,
  input  wire        sleep_active_i,
  // pad levels after the schmitt triggers
  input  wire [7:0]  pad_a_i,
  input  wire [3:0]  pad_b_i,
  // override controls to the pad logic, bit 0..7 port a, 8..11 port b
  output reg  [11:0] pullup_override_en_o,
  output reg  [11:0] pullup_override_value_o,
  output reg  [11:0] direction_override_en_o,
  output reg  [11:0] direction_override_value_o,
  output reg  [11:0] port_value_override_en_o,
  output wire [11:0] port_value_override_value_o,
  output reg  [11:0] input_enable_override_en_o,
  output reg  [11:0] input_enable_override_value_o,
  output reg  [11:0] input_enable_o,
  // digital inputs handed to the peripherals, then the live clock level for pin b1
  output reg         capture_trigger_input_o,
  output reg         counter_external_clock_input_o,
  output reg         receive_data_o,
  output reg         external_irq0_input_o,
  output reg         external_clock_in_pin_o,
  output reg  [11:0] pin_change_source_o,
  output reg  [7:0]  pin_change_group0_o,
  output reg  [3:0]  pin_change_group1_o,
  output wire        system_clock_out_pin_o
);

  reg                       rst_meta;
  reg                       rst_sync_n;
  reg  [`PAF_CTRL_WIDTH-1:0] ctrl;
  reg  [`PAF_SRC_WIDTH-1:0]  src_mask;
  reg  [`PAF_DIS_WIDTH-1:0]  dig_dis;
  reg  [11:0]               pad_meta;
  reg  [11:0]               pad_sync;
  reg  [11:0]               port_value_override_value_q;
  reg  [11:0]               pullup_override_en;
  reg  [11:0]               pullup_override_value;
  reg  [11:0]               direction_override_en;
  reg  [11:0]               direction_override_value;
  reg  [11:0]               port_value_override_en;
  reg  [11:0]               port_value_override_value;
  reg  [11:0]               ieoe;
  reg  [11:0]               ieov;
  reg  [31:0]               next_rdata;
  wire [11:0]               next_ie;
  wire [11:0]               next_di;
  wire                      relocate;
  wire                      group0;
  wire                      group1;
  wire                      rst_dis;
  wire                      clk_out;
  wire                      wr_en;
  wire                      rd_setup;
  wire                      mapped;

  // true when the word address selects the given offset
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr[7:2] == off[7:2]);
    end
  endfunction

  // reset released through two flops, asserted at once
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // pads are asynchronous; only the second stage is read
  always @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pad_meta <= 12'h000;
      pad_sync <= 12'h000;
    end else if (ce_i) begin
      pad_meta <= {pad_b_i, pad_a_i};
      pad_sync <= pad_meta;
    end
  end

  assign relocate = ctrl[`PAF_CTRL_RELOCATE];
  assign group0   = ctrl[`PAF_CTRL_GROUP0_EN];
  assign group1   = ctrl[`PAF_CTRL_GROUP1_EN];
  assign rst_dis  = ctrl[`PAF_CTRL_RST_DIS];
  assign clk_out  = ctrl[`PAF_CTRL_CLK_OUT];

  // apb decode; zero wait states, frozen with the clock enable
  assign mapped    = hit(paddr_i, `PAF_OFF_CTRL) | hit(paddr_i, `PAF_OFF_SRC_MASK) |
                     hit(paddr_i, `PAF_OFF_DIG_DIS) | hit(paddr_i, `PAF_OFF_IE_STAT) |
                     hit(paddr_i, `PAF_OFF_OVR_STAT);
  assign pready_o  = ce_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign wr_en     = psel_i & penable_i & pwrite_i & ce_i & mapped;
  assign rd_setup  = psel_i & ~penable_i & ~pwrite_i & ce_i;

  // register writes; status words ignore writes
  always @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl     <= `PAF_CTRL_RESET;
      src_mask <= `PAF_SRC_RESET;
      dig_dis  <= `PAF_DIS_RESET;
    end else if (wr_en) begin
      if (hit(paddr_i, `PAF_OFF_CTRL)) begin
        ctrl <= pwdata_i[`PAF_CTRL_WIDTH-1:0];
      end
      if (hit(paddr_i, `PAF_OFF_SRC_MASK)) begin
        src_mask <= pwdata_i[`PAF_SRC_WIDTH-1:0];
      end
      if (hit(paddr_i, `PAF_OFF_DIG_DIS)) begin
        dig_dis <= pwdata_i[`PAF_DIS_WIDTH-1:0];
      end
    end
  end

  // read mux; unused upper bits read zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit(paddr_i, `PAF_OFF_CTRL)) begin
      next_rdata[`PAF_CTRL_WIDTH-1:0] = ctrl;
    end else if (hit(paddr_i, `PAF_OFF_SRC_MASK)) begin
      next_rdata[`PAF_SRC_WIDTH-1:0] = src_mask;
    end else if (hit(paddr_i, `PAF_OFF_DIG_DIS)) begin
      next_rdata[`PAF_DIS_WIDTH-1:0] = dig_dis;
    end else if (hit(paddr_i, `PAF_OFF_IE_STAT)) begin
      next_rdata[11:0]  = input_enable_o;
      next_rdata[27:16] = input_enable_override_en_o;
    end else if (hit(paddr_i, `PAF_OFF_OVR_STAT)) begin
      next_rdata[11:0]  = port_value_override_en_o;
      next_rdata[27:16] = direction_override_en_o;
    end
  end

  // read data captured in the setup cycle, stable through access
  always @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_o <= next_rdata;
    end
  end

  // per-pin override equations; unlisted pins default to no override
  always @* begin
    pullup_override_en = 12'h000;
    pullup_override_value = 12'h000;
    direction_override_en = 12'h000;
    direction_override_value = 12'h000;
    port_value_override_en = 12'h000;
    port_value_override_value = 12'h000;
    ieoe = 12'h000;
    ieov = 12'h000;

    // port a pin 0: external clock input
    pullup_override_en[`PAF_PA0] = external_clock_selected_i;
    direction_override_en[`PAF_PA0] = external_clock_selected_i;
    port_value_override_en[`PAF_PA0] = external_clock_selected_i;
    ieoe[`PAF_PA0] = external_clock_selected_i | (src_mask[0] & group0) |
                     dig_dis[0];
    ieov[`PAF_PA0] = external_clock_selected_i &
                     (power_down_sleep_i | (src_mask[0] & group0));

    // port a pin 1: relocated compare-b
    port_value_override_en[`PAF_PA1] = compare_b_en_i & relocate;
    port_value_override_value[`PAF_PA1] = compare_b_output_i & relocate;
    ieoe[`PAF_PA1] = (src_mask[1] & group0) | dig_dis[1];
    ieov[`PAF_PA1] = src_mask[1] & group0;

    // port a pin 2: reset pin when the fuse is not set
    pullup_override_en[`PAF_PA2] = rst_dis;
    pullup_override_value[`PAF_PA2] = 1'b1;
    direction_override_en[`PAF_PA2] = rst_dis;
    ieoe[`PAF_PA2] = rst_dis | (src_mask[2] & group0);
    ieov[`PAF_PA2] = rst_dis & src_mask[2] & group0;

    // port a pin 3: relocated compare-a
    port_value_override_en[`PAF_PA3] = compare_a_en_i & relocate;
    port_value_override_value[`PAF_PA3] = compare_a_output_i & relocate;
    ieoe[`PAF_PA3] = src_mask[3] & group0;
    ieov[`PAF_PA3] = src_mask[3] & group0;

    // port a pin 4: relocated capture input
    ieoe[`PAF_PA4] = src_mask[4] & group0;
    ieov[`PAF_PA4] = src_mask[4] & group0;

    // port a pin 5: relocated compare-b, analog channel 2
    port_value_override_en[`PAF_PA5] = compare_b_en_i & relocate;
    port_value_override_value[`PAF_PA5] = compare_b_output_i & relocate;
    ieoe[`PAF_PA5] = (src_mask[5] & group0) | dig_dis[2];
    ieov[`PAF_PA5] = src_mask[5] & group0;

    // port a pins 6 and 7
    ieoe[`PAF_PA6] = (src_mask[6] & group0) | dig_dis[3];
    ieov[`PAF_PA6] = src_mask[6] & group0;
    ieoe[`PAF_PA7] = src_mask[7] & group0;
    ieov[`PAF_PA7] = src_mask[7] & group0;

    // port b pin 0
    ieoe[`PAF_PB0] = (src_mask[8] & group1) | dig_dis[4];
    ieov[`PAF_PB0] = src_mask[8] & group1;

    // port b pin 1: clock output beats data and direction settings
    pullup_override_en[`PAF_PB1] = clk_out;
    direction_override_en[`PAF_PB1] = clk_out;
    direction_override_value[`PAF_PB1] = clk_out;
    port_value_override_en[`PAF_PB1] = clk_out;
    ieoe[`PAF_PB1] = (src_mask[9] & group1) | dig_dis[5];
    ieov[`PAF_PB1] = src_mask[9] & group1;

    // port b pin 2: serial transmit
    pullup_override_en[`PAF_PB2] = transmitter_enable_i;
    direction_override_en[`PAF_PB2] = transmitter_enable_i;
    direction_override_value[`PAF_PB2] = transmitter_enable_i;
    port_value_override_en[`PAF_PB2] = transmitter_enable_i;
    port_value_override_value[`PAF_PB2] = transmitter_enable_i & transmit_serial_bit_i;
    ieoe[`PAF_PB2] = (src_mask[10] & group1) | dig_dis[6];
    ieov[`PAF_PB2] = src_mask[10] & group1;

    // port b pin 3: receive and comparator output; comparator also claims direction
    pullup_override_en[`PAF_PB3] = comparator_output_pin_en_i;
    direction_override_en[`PAF_PB3] = receiver_enable_i | comparator_output_pin_en_i;
    direction_override_value[`PAF_PB3] = comparator_output_pin_en_i;
    port_value_override_en[`PAF_PB3] = comparator_output_pin_en_i;
    port_value_override_value[`PAF_PB3] = comparator_result_i & comparator_output_pin_en_i;
    ieoe[`PAF_PB3] = (src_mask[11] & group1) | dig_dis[7];
    ieov[`PAF_PB3] = src_mask[11] & group1;
  end

  // final input enable and gated digital input for every pin
  genvar g;
  generate
    for (g = 0; g < `PAF_PIN_COUNT; g = g + 1) begin : gen_pin
      assign next_ie[g] = ieoe[g] ? ieov[g] : ~sleep_active_i;
      assign next_di[g] = pad_sync[g] & next_ie[g];
    end
  endgenerate

  // registered overrides; one cycle behind their causes
  always @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pullup_override_en_o          <= 12'h000;
      pullup_override_value_o       <= 12'h000;
      direction_override_en_o       <= 12'h000;
      direction_override_value_o    <= 12'h000;
      port_value_override_en_o      <= 12'h000;
      port_value_override_value_q                        <= 12'h000;
      input_enable_override_en_o    <= 12'h000;
      input_enable_override_value_o <= 12'h000;
      input_enable_o                <= 12'h000;
    end else if (ce_i) begin
      pullup_override_en_o          <= pullup_override_en;
      pullup_override_value_o       <= pullup_override_value;
      direction_override_en_o       <= direction_override_en;
      direction_override_value_o    <= direction_override_value;
      port_value_override_en_o      <= port_value_override_en;
      port_value_override_value_q                        <= port_value_override_value;
      input_enable_override_en_o    <= ieoe;
      input_enable_override_value_o <= ieov;
      input_enable_o                <= next_ie;
    end
  end

  // the clock itself cannot pass a flop, so pin b1 value is gated live
  assign system_clock_out_pin_o      = clk_out & clk_i;
  assign port_value_override_value_o = {port_value_override_value_q[11:10], system_clock_out_pin_o, port_value_override_value_q[8:0]};

  // digital inputs to the peripherals; relocation moves capture and counter clock
  always @(posedge clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      capture_trigger_input_o        <= 1'b0;
      counter_external_clock_input_o <= 1'b0;
      receive_data_o                 <= 1'b0;
      external_irq0_input_o          <= 1'b0;
      external_clock_in_pin_o        <= 1'b0;
      pin_change_source_o            <= 12'h000;
      pin_change_group0_o            <= 8'h00;
      pin_change_group1_o            <= 4'h0;
    end else if (ce_i) begin
      capture_trigger_input_o        <= relocate ? next_di[`PAF_PA4]
                                                 : next_di[`PAF_PB2];
      counter_external_clock_input_o <= relocate ? next_di[`PAF_PB3]
                                                 : next_di[`PAF_PA0];
      receive_data_o                 <= next_di[`PAF_PB3];
      external_irq0_input_o          <= next_di[`PAF_PB1];
      external_clock_in_pin_o        <= next_di[`PAF_PA0];
      pin_change_source_o            <= next_di & src_mask;
      pin_change_group0_o            <= next_di[7:0] & src_mask[7:0] & {8{group0}};
      pin_change_group1_o            <= next_di[11:8] & src_mask[11:8] & {4{group1}};
    end
  end

endmodule

// ===== verification/paf_periph_model.sv
// model of the timer, serial, comparator and clock peripherals
// assumes the bench hands it wanted levels in the clk_i domain
`timescale 1ns/10ps
module paf_periph_model (
  // clock and wanted levels
  input  logic        clk_i,
  input  logic [11:0] want_i,
  // peripheral levels, same bit order as want_i
  output logic [11:0] level_o
);
  // quiet levels before the first edge so the block never sees unknowns
  initial level_o = 12'h000;
  // levels move just after an edge, as the peripherals' own flops would;
  // compare-a on port a pin 3 relies on software setting it as an output
  always @(posedge clk_i) begin
    level_o <= want_i;
  end
endmodule

// ===== verification/paf_override_monitor.sv
// checker of the override outputs against the peripheral levels
// assumes one clock domain and bind to the override block's ports
`timescale 1ns/10ps
module paf_override_monitor (
  // clock, enable and reset
  input logic clk_i, ce_i, resetn_i,
  // peripheral levels and clock pin
  input logic compare_a_output_i, compare_a_en_i, compare_b_output_i, compare_b_en_i,
  input logic comparator_result_i, comparator_output_pin_en_i, receiver_enable_i,
  input logic transmitter_enable_i, transmit_serial_bit_i, external_clock_selected_i,
  input logic power_down_sleep_i, sleep_active_i, system_clock_out_pin_o,
  // override vectors
  input logic [11:0] pullup_override_en_o, pullup_override_value_o, direction_override_en_o,
  input logic [11:0] direction_override_value_o, port_value_override_en_o,
  input logic [11:0] port_value_override_value_o, input_enable_override_en_o,
  input logic [11:0] input_enable_override_value_o, input_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [1:0] up;
  logic [5:0] drv [12];
  // internal reset lags two flops, so hold off checks for three edges
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  wire ok = (up == 2'h3) && ce_i;
  // pad controls of one pin gathered for short comparisons
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      drv[i] = {pullup_override_en_o[i], pullup_override_value_o[i], direction_override_en_o[i],
                direction_override_value_o[i], port_value_override_en_o[i],
                port_value_override_value_o[i]};
    end
  end
  a_tx_pin_drive: assert property (ok && $past(ok) |-> drv[10] ==
    $past({transmitter_enable_i, 1'b0, {3{transmitter_enable_i}},
           transmitter_enable_i & transmit_serial_bit_i}))
    else $error("transmit pin override wrong");
  a_cmp_pin_drive: assert property (ok && $past(ok) |-> drv[11] ==
    $past({comparator_output_pin_en_i, 1'b0, receiver_enable_i | comparator_output_pin_en_i,
           {2{comparator_output_pin_en_i}}, comparator_result_i & comparator_output_pin_en_i}))
    else $error("comparator pin override wrong");
  a_ext_clk_pin: assert property (ok && $past(ok && external_clock_selected_i) |->
    drv[0] == 6'h2a)
    else $error("external clock pin not released to input");
  a_ext_in_enable: assert property (ok && $past(ok) |->
    (input_enable_override_value_o[0] ? $past(external_clock_selected_i)
      : !$past(external_clock_selected_i && power_down_sleep_i))
    && (input_enable_override_en_o[0] || !$past(external_clock_selected_i)))
    else $error("external clock input enable wrong");
  a_reloc_b_pins: assert property (ok && $past(ok) |-> drv[1][1:0] == drv[5][1:0] &&
    (!port_value_override_en_o[5] || $past({compare_b_en_i, compare_b_output_i}) == drv[5][1:0]))
    else $error("compare-b pins disagree");
  a_reloc_a_pin: assert property (ok && $past(ok) |-> !port_value_override_en_o[3] ||
    $past({compare_a_en_i, compare_a_output_i}) == drv[3][1:0])
    else $error("compare-a pin override wrong");
  a_clk_out_pin: assert property (@(negedge clk_i) disable iff (!resetn_i)
    system_clock_out_pin_o |-> ##1 port_value_override_en_o[9])
    else $error("clock pin toggles without value override");
  a_ie_sleep_path: assert property (ok && $past(ok) && $stable(sleep_active_i) &&
    $stable(input_enable_override_en_o) && $stable(input_enable_override_value_o) |->
    input_enable_o == ((input_enable_override_en_o & input_enable_override_value_o)
      | (~input_enable_override_en_o & {12{!sleep_active_i}})))
    else $error("input enable does not follow override or sleep");
  a_ie_value_gated: assert property (ok |->
    (input_enable_override_value_o & ~input_enable_override_en_o) == 12'h000)
    else $error("input enable value without its override");
endmodule

// ===== verification/tb.sv
// self-checking bench of the port override block
// assumes the peripheral model drives the block's peripheral levels
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'b0, ce_i = 1'b1, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, pready_o, pslverr_o, rerr, compare_a_output_i, compare_a_en_i;
  logic compare_b_output_i, compare_b_en_i, comparator_result_i, comparator_output_pin_en_i;
  logic receiver_enable_i, transmitter_enable_i, transmit_serial_bit_i, sleep_active_i;
  logic external_clock_selected_i, power_down_sleep_i, capture_trigger_input_o;
  logic counter_external_clock_input_o, receive_data_o, external_irq0_input_o;
  logic external_clock_in_pin_o, system_clock_out_pin_o;
  logic [7:0] paddr_i = 8'h00, pad_a_i = 8'h00, pin_change_group0_o;
  logic [3:0] pad_b_i = 4'h0, pin_change_group1_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rdat;
  logic [11:0] pullup_override_en_o, pullup_override_value_o, direction_override_en_o;
  logic [11:0] direction_override_value_o, port_value_override_en_o, port_value_override_value_o;
  logic [11:0] input_enable_override_en_o, input_enable_override_value_o, input_enable_o;
  logic [11:0] pin_change_source_o, want = 12'h000, lv;
  logic [31:0] rst_exp [5] = '{32'h0, 32'h0, 32'h0, 32'h0fff, 32'h0};
  logic [31:0] msk [3] = '{32'h1f, 32'hfff, 32'hff};
  int n_mismatch = 0, cmp_count = 0, cyc = 0;

  paf_override uut (.*);
  paf_periph_model peri (.clk_i(clk_i), .want_i(want), .level_o(lv));
  assign {sleep_active_i, power_down_sleep_i, external_clock_selected_i, transmit_serial_bit_i,
          transmitter_enable_i, receiver_enable_i, comparator_output_pin_en_i,
          comparator_result_i, compare_b_en_i, compare_b_output_i, compare_a_en_i,
          compare_a_output_i} = lv;

  // 10 MHz clock
  initial forever #50 clk_i = ~clk_i;

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  task conclude;
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rdat, e);
  endtask

  task step(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  function automatic logic [7:0] pin(input int i);
    return {pullup_override_en_o[i], pullup_override_value_o[i], direction_override_en_o[i],
            direction_override_value_o[i], port_value_override_en_o[i],
            port_value_override_value_o[i], input_enable_override_en_o[i],
            input_enable_override_value_o[i]};
  endfunction

  // set peripherals and registers, let overrides settle, check one pin
  task ovr(input logic [11:0] w, input logic [4:0] c, input logic [11:0] s,
           input logic [7:0] g, input int p, input logic [7:0] e);
    want <= w;
    wr(8'h00, {27'h0, c});
    wr(8'h04, {20'h0, s});
    wr(8'h08, {24'h0, g});
    step(3);
    chk({24'h0, pin(p)}, {24'h0, e});
  endtask

  initial begin
    step(10);
    resetn_i <= 1'b1;
    step(3);
    // reset values, field widths, read-only and unmapped places
    foreach (rst_exp[i]) rd(8'(4 * i), rst_exp[i]);
    for (int i = 0; i < 3; i++) begin
      wr(8'(4 * i), 32'hffff_ffff);
      rd(8'(4 * i), msk[i]);
      wr(8'(4 * i), 32'h0);
    end
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0);
    apb(8'h40, 1'b0, 32'h0);
    chk({rerr, rdat[30:0]}, 32'h8000_0000);
    // clock enable low must hold the overrides; no bus traffic while pready is low
    ce_i <= 1'b0;
    want <= 12'h180;
    step(4);
    chk({24'h0, pin(10)}, 32'h0);
    ce_i <= 1'b1;
    // peripheral and register takeovers, one pin at a time except the three relocated compare pins
    ovr(12'h180, 5'h00, 12'h000, 8'h00, 10, 8'hbc);
    ovr(12'h080, 5'h00, 12'h000, 8'h00, 10, 8'hb8);
    ovr(12'h040, 5'h00, 12'h000, 8'h00, 11, 8'h20);
    ovr(12'h070, 5'h00, 12'h000, 8'h00, 11, 8'hbc);
    ovr(12'h00f, 5'h01, 12'h000, 8'h00, 5, 8'h0c);
    chk({24'h0, pin(1)}, 32'h0c);
    chk({24'h0, pin(3)}, 32'h0c);
    ovr(12'h00b, 5'h01, 12'h000, 8'h00, 5, 8'h08);
    ovr(12'h00f, 5'h00, 12'h000, 8'h00, 3, 8'h00);
    ovr(12'h600, 5'h00, 12'h000, 8'h00, 0, 8'hab);
    ovr(12'h200, 5'h00, 12'h000, 8'h00, 0, 8'haa);
    ovr(12'h000, 5'h08, 12'h000, 8'h00, 2, 8'he2);
    ovr(12'h000, 5'h0a, 12'h004, 8'h00, 2, 8'he3);
    ovr(12'h000, 5'h02, 12'h002, 8'h00, 1, 8'h03);
    ovr(12'h000, 5'h02, 12'h020, 8'h00, 5, 8'h03);
    ovr(12'h000, 5'h00, 12'h000, 8'h04, 5, 8'h02);
    // digital disable and sleep against the input enables
    ovr(12'h000, 5'h00, 12'h000, 8'hc7, 11, 8'h02);
    chk({20'h0, input_enable_override_en_o}, 32'h0c23);
    chk({20'h0, input_enable_o}, 32'h03dc);
    ovr(12'h800, 5'h00, 12'h000, 8'hc7, 10, 8'h02);
    chk({20'h0, input_enable_o}, 32'h0);
    // port b pads into group 1, capture and receive
    pad_b_i <= 4'hc;
    ovr(12'h000, 5'h04, 12'hc00, 8'h00, 11, 8'h03);
    chk({22'h0, pin_change_group1_o, pin_change_source_o[11:8], capture_trigger_input_o,
         receive_data_o}, 32'h0333);
    // relocation moves capture to a4 and counter clock to b3; group 0 and clock inputs too
    pad_a_i <= 8'h11;
    pad_b_i <= 4'ha;
    ovr(12'h000, 5'h07, 12'h830, 8'h00, 11, 8'h03);
    chk({16'h0, pin_change_group0_o, pin_change_group1_o, counter_external_clock_input_o,
         capture_trigger_input_o, external_clock_in_pin_o, external_irq0_input_o}, 32'h108f);
    pad_a_i <= 8'h00;
    pad_b_i <= 4'h0;
    step(5);
    chk({22'h0, pin_change_group1_o, pin_change_source_o[11:8], capture_trigger_input_o,
         receive_data_o}, 32'h0);
    // system clock on port b pin 1
    wr(8'h00, 32'h10);
    step(3);
    #10 chk({30'h0, port_value_override_en_o[9], system_clock_out_pin_o}, 32'h3);
    @(negedge clk_i);
    #10 chk({31'h0, system_clock_out_pin_o}, 32'h0);
    wr(8'h00, 32'h0);
    step(3);
    conclude();
  end
endmodule

bind paf_override paf_override_monitor mon (.*);
